// ### rtl/fsd_shaping_top.sv
// Summary of operation
// R1 - Shaping steps through 16 intermediate frequencies
// R2 - Seven values, other half mirrored anti-symmetrically
// R3 - Shaping only while enable bit set
// R4 - Software keeps separation at most 63
// R5 - Step length set by step delay register
// R6 - Software picks delay as fref/(16*baud)-1
// R7 - Reference tick is clock over reference divider
// R8 - Reset shaping_enable values give raised cosine
// R9 - Two-bit dither field drives synthesizer dithering
// R10 - Software sets bypass for external clock
// R11 - Software sets range field to reference band
// R12 - Data edge restarts staircase, advance, hold
// R13 - Mirror negated reversed, direction follows edge
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module fsd_shaping_top
  import fsd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [FSD_AW-1:0] regAddr,
  input wire logic [FSD_DW-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [FSD_DW-1:0] regRdata,
  // Transmit data pin
  input wire logic txDataPin,
  // Synthesizer control
  output logic signed [7:0] synthOffset,
  output logic [1:0] ditherSel,
  output logic stepBusy,
  // Oscillator configuration
  output logic oscBypass,
  output logic [1:0] oscRange
);

  logic [7:0] ctrl_reg;
  logic [7:0] delay_reg;
  logic [7:0] reference_divider_reg;
  logic [7:0] sep_reg;
  logic [7:0] osc_reg;
  logic [7:0] shaping_enable_reg [SHAPING_ENABLE_REGS];
  logic txMeta_reg;
  logic txSync2_reg;
  logic txSync3_reg;
  logic txLevel_reg;
  logic dataChange;
  logic shapingEnable;
  fsd_state_t state_reg;
  logic [3:0] stepIdx_reg;
  logic [7:0] stepCnt_reg;
  logic stepTick;
  logic signed [7:0] stair_next;
  logic [7:0] rdata_next;
  fsd_ref_if refBus ();

  function automatic logic shapeHit(input logic [3:0] addr, input int k);
    shapeHit = (addr == ADDR_SHAPE0 + 4'(k));
  endfunction : shapeHit

  assign shapingEnable = ctrl_reg[CTRL_SHAPING_ENABLE_BIT];
  assign refBus.divisor = reference_divider_reg;

  fsd_ref_divider i_fsd_ref_divider (
    .clk (clk),
    .rstn (rstn),
    .refPort (refBus.divider)
  );

  // Configuration registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= CTRL_RST;
      delay_reg <= DELAY_RST;
      reference_divider_reg <= REF_DIVIDER_RST;
      sep_reg <= SEP_RST;
      osc_reg <= OSC_RST;
    end else if (regWr) begin
      case (regAddr)
        ADDR_CTRL: ctrl_reg <= {5'h00, regWdata[2:0]};
        ADDR_DELAY: delay_reg <= regWdata;
        ADDR_REF_DIVIDER: reference_divider_reg <= regWdata;
        ADDR_SEP: sep_reg <= regWdata;
        ADDR_OSC: osc_reg <= {5'h00, regWdata[2:0]};
        default: ;
      endcase
    end
  end

  generate
    for (genvar k = 0; k < SHAPING_ENABLE_REGS; k++) begin : g_shaping_enable
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          shaping_enable_reg[k] <= SHAPING_ENABLE_RST[k]; // [R8]
        end else if (regWr && shapeHit(regAddr, k)) begin
          shaping_enable_reg[k] <= regWdata;
        end
      end
    end
  endgenerate

  // Read data stands only in the cycle after the strobe
  always_comb begin
    rdata_next = 8'h00;
    case (regAddr)
      ADDR_CTRL: rdata_next = ctrl_reg;
      ADDR_DELAY: rdata_next = delay_reg;
      ADDR_REF_DIVIDER: rdata_next = reference_divider_reg;
      ADDR_SEP: rdata_next = sep_reg;
      ADDR_OSC: rdata_next = osc_reg;
      ADDR_STATUS: begin
        rdata_next[STAT_IDX_LSB +: 4] = stepIdx_reg;
        rdata_next[STAT_LEVEL_BIT] = txLevel_reg;
        rdata_next[STAT_BUSY_BIT] = stepBusy;
      end
      default: begin
        for (int k = 0; k < SHAPING_ENABLE_REGS; k++) begin
          if (shapeHit(regAddr, k)) begin
            rdata_next = shaping_enable_reg[k];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      regRdata <= rdata_next;
    end else begin
      regRdata <= 8'h00;
    end
  end

  // Pin synchroniser; a change counts once stages two and three agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txMeta_reg <= 1'b0;
      txSync2_reg <= 1'b0;
      txSync3_reg <= 1'b0;
    end else begin
      txMeta_reg <= txDataPin;
      txSync2_reg <= txMeta_reg;
      txSync3_reg <= txSync2_reg;
    end
  end

  assign dataChange = (txSync2_reg == txSync3_reg) && (txSync3_reg != txLevel_reg);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txLevel_reg <= 1'b0;
    end else if (dataChange) begin
      txLevel_reg <= txSync3_reg;
    end
  end

  // Step pacing in reference ticks
  assign stepTick = refBus.refTick && (stepCnt_reg == delay_reg); // [R5]

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stepCnt_reg <= 8'h00;
    end else if (dataChange || state_reg != FSD_STAIR || stepTick) begin
      stepCnt_reg <= 8'h00; // [R5]
    end else if (refBus.refTick) begin
      stepCnt_reg <= stepCnt_reg + 8'h01;
    end
  end

  // Staircase sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= FSD_HOLD;
      stepIdx_reg <= LAST_STEP;
    end else begin
      case (state_reg)
        FSD_HOLD: begin
          if (dataChange && shapingEnable) begin
            state_reg <= FSD_STAIR;
            stepIdx_reg <= 4'h0; // [R12]
          end else begin
            stepIdx_reg <= LAST_STEP; // [R3]
          end
        end
        FSD_STAIR: begin
          if (!shapingEnable) begin
            // Disabling mid-staircase jumps straight to the end
            state_reg <= FSD_HOLD;
            stepIdx_reg <= LAST_STEP; // [R3]
          end else if (dataChange) begin
            stepIdx_reg <= 4'h0; // [R12]
          end else if (stepTick) begin
            stepIdx_reg <= stepIdx_reg + 4'h1; // [R1]
            if (stepIdx_reg == LAST_STEP - 4'h1) begin
              state_reg <= FSD_HOLD; // [R12]
            end
          end
        end
        default: begin
          state_reg <= FSD_HOLD;
          stepIdx_reg <= LAST_STEP;
        end
      endcase
    end
  end

  // Rising staircase from -sep to +sep; a falling edge negates it
  always_comb begin
    stair_next = 8'sh00;
    if (stepIdx_reg < MID_STEP) begin
      stair_next = -$signed(shaping_enable_reg[3'(MID_STEP - 4'h1 - stepIdx_reg)]); // [R13]
    end else if (stepIdx_reg == LAST_STEP) begin
      stair_next = $signed({1'b0, sep_reg[6:0]}); // [R1]
    end else if (stepIdx_reg > MID_STEP) begin
      stair_next = $signed(shaping_enable_reg[3'(stepIdx_reg - MID_STEP - 4'h1)]); // [R2]
    end
    if (!txLevel_reg) begin
      stair_next = -stair_next; // [R13]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      synthOffset <= 8'sh00;
    end else begin
      synthOffset <= stair_next;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ditherSel <= 2'h0;
      oscBypass <= 1'b0;
      oscRange <= 2'h0;
      stepBusy <= 1'b0;
    end else begin
      ditherSel <= ctrl_reg[CTRL_DITHER_LSB +: 2]; // [R9]
      oscBypass <= osc_reg[OSC_BYPASS_BIT];
      oscRange <= osc_reg[OSC_RANGE_LSB +: 2];
      stepBusy <= (state_reg == FSD_STAIR);
    end
  end

  restart_idx_a: assert property (@(posedge clk) disable iff (!rstn) // [R12]
    (dataChange && shapingEnable) |=> (stepIdx_reg == 4'h0 && state_reg == FSD_STAIR))
    else $error("staircase did not restart");

  step_advance_a: assert property (@(posedge clk) disable iff (!rstn) // [R5]
    (state_reg == FSD_STAIR && shapingEnable && !dataChange && stepTick)
      |=> stepIdx_reg == $past(stepIdx_reg) + 4'h1)
    else $error("step index did not advance");

  step_hold_a: assert property (@(posedge clk) disable iff (!rstn) // [R5]
    (state_reg == FSD_STAIR && shapingEnable && !dataChange && !refBus.refTick) |=> $stable(stepIdx_reg))
    else $error("step moved without reference tick");

  // A data edge one cycle later may legally restart the staircase
  final_hold_a: assert property (@(posedge clk) disable iff (!rstn) // [R12]
    (state_reg == FSD_HOLD && !dataChange)
      |=> (stepIdx_reg == LAST_STEP) ##1 (stepIdx_reg == LAST_STEP || $past(dataChange)))
    else $error("final step not held");

  no_shaping_a: assert property (@(posedge clk) disable iff (!rstn) // [R3]
    (!shapingEnable && $stable(ctrl_reg) && $stable(sep_reg))
      |=> ##1 (synthOffset == ($past(txLevel_reg) ? $signed({1'b0, $past(sep_reg[6:0])})
        : -$signed({1'b0, $past(sep_reg[6:0])}))))
    else $error("unshaped offset not at full deviation");

  mid_zero_a: assert property (@(posedge clk) disable iff (!rstn) // [R2]
    (stepIdx_reg == MID_STEP) |=> synthOffset == 8'sh00)
    else $error("centre step not zero");

  mirror_a: assert property (@(posedge clk) disable iff (!rstn) // [R13]
    (stepIdx_reg == 4'h0 && txLevel_reg) |=> synthOffset == -$signed($past(shaping_enable_reg[SHAPING_ENABLE_REGS-1])))
    else $error("mirrored first step wrong");

  dither_out_a: assert property (@(posedge clk) disable iff (!rstn) // [R9]
    (regWr && regAddr == ADDR_CTRL) |=> ##1 ditherSel == $past(regWdata[CTRL_DITHER_LSB +: 2], 2))
    else $error("dither field not applied");

  shaping_enable_reset_a: assert property (@(posedge clk) // [R8]
    $rose(rstn) |-> (shaping_enable_reg[0] == SHAPING_ENABLE_RST[0] && shaping_enable_reg[SHAPING_ENABLE_REGS-1] == SHAPING_ENABLE_RST[SHAPING_ENABLE_REGS-1]))
    else $error("shaping_enable reset values wrong");

endmodule : fsd_shaping_top

// ### common/fsd_pkg.sv
package fsd_pkg;

  // Register bus widths
  localparam int FSD_AW = 4;
  localparam int FSD_DW = 8;

  // Register offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_DELAY = 4'h1;
  localparam logic [3:0] ADDR_REF_DIVIDER = 4'h2;
  localparam logic [3:0] ADDR_SHAPE0 = 4'h3;
  localparam logic [3:0] ADDR_SEP = 4'ha;
  localparam logic [3:0] ADDR_OSC = 4'hb;
  localparam logic [3:0] ADDR_STATUS = 4'hc;

  // Field positions
  localparam int CTRL_SHAPING_ENABLE_BIT = 0;
  localparam int CTRL_DITHER_LSB = 1;
  localparam int OSC_BYPASS_BIT = 0;
  localparam int OSC_RANGE_LSB = 1;
  localparam int STAT_IDX_LSB = 0;
  localparam int STAT_LEVEL_BIT = 6;
  localparam int STAT_BUSY_BIT = 7;

  // Staircase geometry
  localparam int SHAPING_ENABLE_REGS = 7;
  localparam logic [3:0] MID_STEP = 4'h7;
  localparam logic [3:0] LAST_STEP = 4'hf;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DELAY_RST = 8'h0f;
  localparam logic [7:0] REF_DIVIDER_RST = 8'h01;
  localparam logic [7:0] SEP_RST = 8'h3f;
  localparam logic [7:0] OSC_RST = 8'h00;
  // Raised-cosine half staircase at a separation of 63, centre outward
  localparam logic [7:0] SHAPING_ENABLE_RST [SHAPING_ENABLE_REGS] = '{8'h0c, 8'h18, 8'h23, 8'h2d, 8'h34, 8'h3a, 8'h3e};

  typedef enum {FSD_HOLD, FSD_STAIR} fsd_state_t;

endpackage : fsd_pkg

// ### common/fsd_ref_if.sv
`timescale 1ns/1ps
interface fsd_ref_if;
  logic [7:0] divisor;
  logic refTick;
  modport divider (input divisor, output refTick);
  modport user (output divisor, input refTick);
endinterface : fsd_ref_if

// ### rtl/fsd_ref_divider.sv
`timescale 1ns/1ps
module fsd_ref_divider
  import fsd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Divisor in, tick out
  fsd_ref_if.divider refPort
);

  logic [7:0] divCnt_reg;
  logic wrap;

  // A divisor of zero behaves as one
  assign wrap = (divCnt_reg + 8'h01 >= refPort.divisor) || (refPort.divisor == 8'h00);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      divCnt_reg <= 8'h00;
    end else if (wrap) begin
      divCnt_reg <= 8'h00; // [R7]
    end else begin
      divCnt_reg <= divCnt_reg + 8'h01;
    end
  end

  assign refPort.refTick = wrap;

  ref_spacing_a: assert property (@(posedge clk) disable iff (!rstn) // [R7]
    (refPort.refTick && refPort.divisor == 8'h02 && $stable(refPort.divisor))
      |=> !refPort.refTick ##1 refPort.refTick)
    else $error("reference tick spacing wrong");

endmodule : fsd_ref_divider

// ### verification/fsd_synth_model.sv
`timescale 1ns/1ps
module fsd_synth_model (
  // Clock
  input wire logic clk,
  // Data source
  input wire logic sendLevel,
  output logic txDataPin,
  // Synthesizer side
  input wire logic signed [7:0] synthOffset,
  output int lastGap
);
  logic signed [7:0] prevOffset = '0;
  int sinceChange = 0;
  // Data changes only just after an edge, like a real modulator
  always @(posedge clk) begin
    txDataPin <= sendLevel;
    prevOffset <= synthOffset;
    if (synthOffset !== prevOffset) begin
      lastGap <= sinceChange;
      sinceChange <= 1;
    end else begin
      sinceChange <= sinceChange + 1;
    end
  end
endmodule : fsd_synth_model

// ### verification/test_fsd_shaping_top.sv
`timescale 1ns/1ps
module test_fsd_shaping_top;
  import fsd_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [FSD_AW-1:0] regAddr = '0;
  logic [FSD_DW-1:0] regWdata = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [FSD_DW-1:0] regRdata;
  logic sendLevel = 1'b0;
  logic txDataPin;
  logic signed [7:0] synthOffset;
  logic [1:0] ditherSel;
  logic stepBusy;
  logic oscBypass;
  logic [1:0] oscRange;
  int lastGap;
  int err_count = 0;
  int n_compared = 0;
  always #2.5 clk = ~clk;
  fsd_shaping_top i_fsd_shaping_top (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .txDataPin(txDataPin), .synthOffset(synthOffset),
    .ditherSel(ditherSel), .stepBusy(stepBusy), .oscBypass(oscBypass), .oscRange(oscRange));
  fsd_synth_model i_fsd_synth_model (.clk(clk), .sendLevel(sendLevel), .txDataPin(txDataPin),
    .synthOffset(synthOffset), .lastGap(lastGap));
  task automatic tally_and_finish();
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk("read data", exp, regRdata);
  endtask : rd
  // Expected offset of step i for a rising edge, negated for falling
  function automatic logic [7:0] stepVal(input int i, input bit rise);
    logic [7:0] v;
    v = (i < 7) ? -SHAPING_ENABLE_RST[6-i] : (i == 7) ? 8'h00 : (i < 15) ? SHAPING_ENABLE_RST[i-8] : 8'h3f;
    return rise ? v : -v;
  endfunction : stepVal
  task automatic waitBusy();
    for (int n = 0; n < 300; n++) begin
      @(posedge clk);
      #1;
      if (stepBusy === 1'b1) return;
    end
    err_count++;
    $display("Error stepBusy expected 1 seen %b", stepBusy);
    tally_and_finish();
  endtask : waitBusy
  task automatic regResetValues();
    rd(ADDR_CTRL, CTRL_RST);
    rd(ADDR_DELAY, DELAY_RST);
    rd(ADDR_REF_DIVIDER, REF_DIVIDER_RST);
    for (int i = 0; i < SHAPING_ENABLE_REGS; i++) rd(ADDR_SHAPE0 + 4'(i), SHAPING_ENABLE_RST[i]);
    rd(ADDR_SEP, SEP_RST);
    rd(ADDR_OSC, OSC_RST);
    rd(4'hd, 8'h00);
    rd(ADDR_STATUS, {4'h0, LAST_STEP});
  endtask : regResetValues
  task automatic abruptShift();
    sendLevel <= 1'b1;
    repeat (8) @(posedge clk);
    #1 chk("unshaped offset", 8'h3f, synthOffset);
  endtask : abruptShift
  task automatic staircase(input bit rise);
    sendLevel <= rise;
    waitBusy();
    chk("step 0", stepVal(0, rise), synthOffset);
    for (int i = 1; i < 16; i++) begin
      @(posedge clk);
      #1 chk("step", stepVal(i, rise), synthOffset);
    end
    repeat (4) @(posedge clk);
    #1 chk("final hold", stepVal(15, rise), synthOffset);
    chk("busy low", 8'h00, {7'h0, stepBusy});
  endtask : staircase
  task automatic stepTiming();
    wr(ADDR_DELAY, 8'h02);
    wr(ADDR_REF_DIVIDER, 8'h02);
    sendLevel <= 1'b0;
    waitBusy();
    repeat (30) @(posedge clk);
    #1 chk("step length", 8'd6, 8'(lastGap));
    wait_done: repeat (150) @(posedge clk);
  endtask : stepTiming
  task automatic fieldsOut();
    wr(ADDR_CTRL, 8'hff);
    rd(ADDR_CTRL, 8'h07);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CTRL, 8'(k << 1));
      wr(ADDR_OSC, 8'((k << 1) | (k & 1)));
      @(posedge clk);
      #1 chk("dither", 8'(k), {6'h0, ditherSel});
      chk("range", 8'(k), {6'h0, oscRange});
      chk("bypass", 8'(k & 1), {7'h0, oscBypass});
    end
    wr(ADDR_SEP, 8'h2a);
    rd(ADDR_SEP, 8'h2a);
    chk("unshaped offset", 8'hd6, synthOffset);
    wr(ADDR_SHAPE0, 8'h11);
    rd(ADDR_SHAPE0, 8'h11);
  endtask : fieldsOut
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    regResetValues();
    abruptShift();
    wr(ADDR_DELAY, 8'h00);
    wr(ADDR_CTRL, 8'h01);
    staircase(1'b0);
    staircase(1'b1);
    stepTiming();
    fieldsOut();
    tally_and_finish();
  end
endmodule : test_fsd_shaping_top
